// file: src/nsf_frame_builder.sv
/*
  Procedure-entry frame builder: pushes the old frame base, copies the
  caller's display, pushes the new frame pointer when the depth is nonzero, sets the frame base and
  reserves dynamic storage.
  Assumes stack memory answers reads with a one-cycle-or-later rd_valid
  and accepts writes when wr_ready is high.
*/
`timescale 1ns/10ps
`default_nettype none
module nsf_frame_builder #(
  parameter int COUNT_W = nsf_pkg::COUNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core command
  input wire logic start,
  input wire logic [COUNT_W-1:0] storage_bytes,
  input wire logic [nsf_pkg::DEPTH_W-1:0] nest_depth,
  input wire logic load_ptrs,
  input wire logic [31:0] load_stack_pointer,
  input wire logic [31:0] load_frame_base_pointer,
  output logic busy,
  output logic done,
  output logic [31:0] stack_pointer,
  output logic [31:0] frame_base_pointer,
  // Memory operand segment choice
  input wire logic mem_valid,
  input wire logic [2:0] base_reg,
  input wire logic seg_override,
  input wire nsf_pkg::nsf_seg_e override_seg,
  output nsf_pkg::nsf_seg_e mem_seg,
  // Stack memory
  output logic wr_en,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  input wire logic wr_ready,
  output logic rd_en,
  output logic [31:0] rd_addr,
  input wire logic rd_valid,
  input wire logic [31:0] rd_data
);
  // ==========================================================
  // State
  nsf_pkg::nsf_state_e state;
  logic [31:0] recorded_stack_top;
  logic [31:0] storage;
  logic [4:0] copies_left;
  logic [31:0] disp_word;
  logic [31:0] next_sp;

  // Pushes pre-decrement the stack pointer
  assign next_sp = stack_pointer - nsf_pkg::SLOT_BYTES;

  // ==========================================================
  // Sequencer
  // Depth is taken as a plain count; no privilege input exists
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= nsf_pkg::NSF_IDLE;
    end else begin
      case (state)
        nsf_pkg::NSF_IDLE: begin
          if (start) begin
            state <= nsf_pkg::NSF_PUSH_OLD;
          end
        end
        nsf_pkg::NSF_PUSH_OLD: begin
          if (wr_ready) begin
            if (copies_left == 5'h00) begin
              state <= nsf_pkg::NSF_FINISH;
            end else if (copies_left == 5'h01) begin
              state <= nsf_pkg::NSF_PUSH_TOP;
            end else begin
              state <= nsf_pkg::NSF_READ_DISP;
            end
          end
        end
        nsf_pkg::NSF_READ_DISP: state <= nsf_pkg::NSF_WAIT_DISP;
        nsf_pkg::NSF_WAIT_DISP: begin
          if (rd_valid) begin
            state <= nsf_pkg::NSF_PUSH_DISP;
          end
        end
        nsf_pkg::NSF_PUSH_DISP: begin
          if (wr_ready) begin
            if (copies_left == 5'h02) begin
              state <= nsf_pkg::NSF_PUSH_TOP;
            end else begin
              state <= nsf_pkg::NSF_READ_DISP;
            end
          end
        end
        nsf_pkg::NSF_PUSH_TOP: begin
          if (wr_ready) begin
            state <= nsf_pkg::NSF_FINISH;
          end
        end
        nsf_pkg::NSF_FINISH: state <= nsf_pkg::NSF_IDLE;
        default: state <= nsf_pkg::NSF_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Operand capture and copy count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      storage <= nsf_pkg::PTR_RESET;
      copies_left <= 5'h00;
    end else if (state == nsf_pkg::NSF_IDLE && start) begin
      storage <= 32'(storage_bytes);
      copies_left <= nest_depth & nsf_pkg::DEPTH_MAX;
    end else if (state == nsf_pkg::NSF_PUSH_DISP && wr_ready) begin
      copies_left <= copies_left - 5'h01;
    end
  end

  // ==========================================================
  // Read data holding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      disp_word <= nsf_pkg::PTR_RESET;
    end else if (state == nsf_pkg::NSF_WAIT_DISP && rd_valid) begin
      disp_word <= rd_data;
    end
  end

  // ==========================================================
  // Pointer registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stack_pointer <= nsf_pkg::PTR_RESET;
      frame_base_pointer <= nsf_pkg::PTR_RESET;
      recorded_stack_top <= nsf_pkg::PTR_RESET;
    end else if (state == nsf_pkg::NSF_IDLE) begin
      if (load_ptrs) begin
        stack_pointer <= load_stack_pointer;
        frame_base_pointer <= load_frame_base_pointer;
      end
    end else begin
      case (state)
        nsf_pkg::NSF_PUSH_OLD: begin
          if (wr_ready) begin
            stack_pointer <= next_sp;
            recorded_stack_top <= next_sp;
          end
        end
        nsf_pkg::NSF_READ_DISP: begin
          frame_base_pointer <= frame_base_pointer -
                                nsf_pkg::SLOT_BYTES;
        end
        nsf_pkg::NSF_PUSH_DISP, nsf_pkg::NSF_PUSH_TOP: begin
          if (wr_ready) begin
            stack_pointer <= next_sp;
          end
        end
        nsf_pkg::NSF_FINISH: begin
          frame_base_pointer <= recorded_stack_top;
          stack_pointer <= stack_pointer - storage;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Memory requests, registered from next state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_en <= 1'b0;
      wr_addr <= nsf_pkg::PTR_RESET;
      wr_data <= nsf_pkg::PTR_RESET;
      rd_en <= 1'b0;
      rd_addr <= nsf_pkg::PTR_RESET;
    end else begin
      rd_en <= 1'b0;
      if (state == nsf_pkg::NSF_IDLE && start) begin
        wr_en <= 1'b1;
        wr_addr <= stack_pointer - nsf_pkg::SLOT_BYTES;
        wr_data <= frame_base_pointer;
      end else if (state == nsf_pkg::NSF_READ_DISP) begin
        rd_en <= 1'b1;
        rd_addr <= frame_base_pointer - nsf_pkg::SLOT_BYTES;
      end else if (state == nsf_pkg::NSF_WAIT_DISP && rd_valid) begin
        wr_en <= 1'b1;
        wr_addr <= next_sp;
        wr_data <= rd_data;
      end else if (wr_en && wr_ready) begin
        if (state == nsf_pkg::NSF_PUSH_OLD && copies_left == 5'h01 ||
            state == nsf_pkg::NSF_PUSH_DISP && copies_left == 5'h02) begin
          wr_en <= 1'b1;
          wr_addr <= next_sp - nsf_pkg::SLOT_BYTES;
          wr_data <= (state == nsf_pkg::NSF_PUSH_OLD) ? next_sp :
                     recorded_stack_top;
        end else begin
          wr_en <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= (state != nsf_pkg::NSF_IDLE && state != nsf_pkg::NSF_FINISH)
              || (state == nsf_pkg::NSF_IDLE && start);
      done <= (state == nsf_pkg::NSF_FINISH);
    end
  end

  // Stack-segment default for frame-based operands
  nsf_seg_select u_seg (
    .clk(clk),
    .rst_n(rst_n),
    .mem_valid(mem_valid),
    .base_reg(base_reg),
    .seg_override(seg_override),
    .override_seg(override_seg),
    .seg(mem_seg)
  );
endmodule
`default_nettype wire

// file: src/nsf_pkg.sv
/*
  Package for the nested stack frame builder: operand widths, step sizes
  and the sequencer state type.
  Assumes a 32-bit stack pointer and doubleword stack slots.
*/
package nsf_pkg;
  // ==========================================================
  // Widths and sizes
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 16;
  localparam int DEPTH_W = 5;
  localparam logic [31:0] SLOT_BYTES = 32'h0000_0004;
  localparam logic [4:0] DEPTH_MAX = 5'h1F;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;

  // ==========================================================
  // Sequencer states
  typedef enum logic [2:0] {
    NSF_IDLE,
    NSF_PUSH_OLD,
    NSF_READ_DISP,
    NSF_WAIT_DISP,
    NSF_PUSH_DISP,
    NSF_PUSH_TOP,
    NSF_FINISH
  } nsf_state_e;

  // Segment selection for memory operands
  typedef enum logic [1:0] {
    NSF_SEG_DATA,
    NSF_SEG_STACK
  } nsf_seg_e;
endpackage

// file: src/nsf_seg_select.sv
/*
  Default segment chooser for memory operands.
  Assumes the base register index is sampled on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
module nsf_seg_select #(
  parameter logic [2:0] FRAME_BASE_IDX = 3'h5,
  parameter logic [2:0] STACK_PTR_IDX = 3'h4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Operand description
  input wire logic mem_valid,
  input wire logic [2:0] base_reg,
  input wire logic seg_override,
  input wire nsf_pkg::nsf_seg_e override_seg,
  // Result
  output nsf_pkg::nsf_seg_e seg
);
  // ==========================================================
  // Registered choice
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seg <= nsf_pkg::NSF_SEG_DATA;
    end else if (mem_valid) begin
      if (seg_override) begin
        seg <= override_seg;
      end else if (base_reg == FRAME_BASE_IDX ||
                   base_reg == STACK_PTR_IDX) begin
        seg <= nsf_pkg::NSF_SEG_STACK;
      end else begin
        seg <= nsf_pkg::NSF_SEG_DATA;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/nsf_frame_props.sv
/* Port checker for the frame builder, bound onto every instance.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module nsf_frame_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command
  input wire logic start,
  input wire logic busy,
  input wire logic done,
  input wire logic [31:0] stack_pointer,
  input wire logic [31:0] frame_base_pointer,
  // Operand segment
  input wire logic mem_valid,
  input wire logic [2:0] base_reg,
  input wire logic seg_override,
  input wire nsf_pkg::nsf_seg_e mem_seg,
  // Stack memory
  input wire logic wr_en,
  input wire logic [31:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_ready,
  input wire logic rd_en
);
  logic [31:0] sp0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ========================================
  // Stack top when a build is taken
  always_ff @(posedge clk) begin
    if (start && !busy && !done) begin
      sp0 <= stack_pointer;
    end
  end
  // ========================================
  // Assertions
  a_push_addr:
    assert property (wr_en |-> wr_addr == stack_pointer - 32'h4)
    else $error("push address off");
  a_push_step:
    assert property (wr_en && wr_ready |=>
      stack_pointer == $past(stack_pointer) - 32'h4)
    else $error("push step off");
  a_write_hold:
    assert property (wr_en && !wr_ready |=>
      wr_en && $stable(wr_addr) && $stable(wr_data))
    else $error("write dropped");
  a_read_pulse:
    assert property (rd_en |=> !rd_en) else $error("read not a pulse");
  a_done_pulse:
    assert property (done |=> !done) else $error("done not a pulse");
  a_start_taken:
    assert property (start && !busy && !done |=> busy)
    else $error("start not taken");
  a_final_base:
    assert property (done |-> frame_base_pointer == sp0 - 32'h4)
    else $error("final base off");
  a_seg_frame:
    assert property (mem_valid && !seg_override && base_reg == 3'h5 |=>
      mem_seg == nsf_pkg::NSF_SEG_STACK)
    else $error("segment not stack");
  c_done: cover property (done);
  c_stall: cover property (wr_en && !wr_ready);
  c_copy: cover property (rd_en ##[1:4] wr_en);
endmodule
bind nsf_frame_builder nsf_frame_props u_props (
  .clk, .rst_n, .start, .busy, .done, .stack_pointer, .frame_base_pointer,
  .mem_valid, .base_reg, .seg_override, .mem_seg, .wr_en, .wr_addr,
  .wr_data, .wr_ready, .rd_en
);
`default_nettype wire

// file: tb/nsf_stack_mem.sv
/* Stack memory model: logs writes by word, answers reads late.
   Assumes the core clock; slow adds write stalls and read latency. */
`timescale 1ns/10ps
`default_nettype none
module nsf_stack_mem (
  // Clock and pacing
  input wire logic clk,
  input wire logic slow,
  // Write side
  input wire logic wr_en,
  input wire logic [31:0] wr_addr,
  input wire logic [31:0] wr_data,
  output logic wr_ready,
  // Read side
  input wire logic rd_en,
  input wire logic [31:0] rd_addr,
  output logic rd_valid,
  output logic [31:0] rd_data
);
  logic [31:0] mem [0:255];
  logic [31:0] ra = 32'h0;
  logic tg = 1'b0;
  logic p1 = 1'b0;
  logic p2 = 1'b0;
  always_ff @(posedge clk) begin
    tg <= ~tg;
    p1 <= rd_en;
    p2 <= p1;
    if (rd_en) begin
      ra <= rd_addr;
    end
    if (wr_en && wr_ready) begin
      mem[wr_addr[9:2]] <= wr_data;
    end
  end
  assign wr_ready = ~slow | tg;
  assign rd_valid = slow ? p2 : p1;
  // Off a valid beat the bus shows a value that cannot pass for data
  assign rd_data = rd_valid ? (ra ^ 32'h5A5A_0000) : ~ra;
endmodule
`default_nettype wire

// file: tb/nsf_frame_builder_bench.sv
/* Self-checking bench for the frame builder.
   Assumes the memory model and checker are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
module nsf_frame_builder_bench;
  localparam logic [31:0] FBP = 32'h0000_0300;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0, load_ptrs = 1'b0, slow = 1'b0;
  logic [15:0] storage_bytes = 16'h0;
  logic [4:0] nest_depth = 5'h0;
  logic [31:0] load_sp = 32'h0, load_fbp = 32'h0;
  logic mem_valid = 1'b0, seg_override = 1'b0;
  logic [2:0] base_reg = 3'h0;
  logic busy, done, wr_en, wr_ready, rd_en, rd_valid;
  logic [31:0] stack_pointer, frame_base_pointer;
  logic [31:0] wr_addr, wr_data, rd_addr, rd_data;
  nsf_pkg::nsf_seg_e mem_seg;
  nsf_pkg::nsf_seg_e override_seg = nsf_pkg::NSF_SEG_STACK;
  int n_mismatch = 0;
  int compares = 0;
  nsf_frame_builder dut (
    .clk, .rst_n, .start, .storage_bytes, .nest_depth, .load_ptrs,
    .load_stack_pointer(load_sp), .load_frame_base_pointer(load_fbp),
    .busy, .done, .stack_pointer, .frame_base_pointer, .mem_valid,
    .base_reg, .seg_override, .override_seg,
    .mem_seg, .wr_en, .wr_addr, .wr_data, .wr_ready, .rd_en, .rd_addr,
    .rd_valid, .rd_data
  );
  nsf_stack_mem u_mem (
    .clk, .slow, .wr_en, .wr_addr, .wr_data, .wr_ready, .rd_en, .rd_addr,
    .rd_valid, .rd_data
  );
  always #12.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // ========================================
  // One build; a second start while busy must be ignored
  task automatic run(input string nm, input logic [31:0] sp,
      input logic [4:0] d, input logic [15:0] nb, input logic sl,
      input logic twice);
    int k;
    logic [31:0] top, a, b;
    top = sp - 32'h4;
    @(posedge clk);
    slow <= sl;
    load_ptrs <= 1'b1;
    load_sp <= sp;
    load_fbp <= FBP;
    @(posedge clk);
    load_ptrs <= 1'b0;
    start <= 1'b1;
    nest_depth <= d;
    storage_bytes <= nb;
    @(posedge clk);
    start <= twice;
    nest_depth <= 5'h02;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk({31'h0, busy}, 32'h1);
    for (k = 0; k < 500 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk({31'h0, done}, 32'h1);
    chk({31'h0, busy}, 32'h0);
    chk(frame_base_pointer, top);
    chk(u_mem.mem[top[9:2]], FBP);
    a = top;
    b = FBP;
    for (k = 1; k < d; k++) begin
      a = a - 32'h4;
      b = b - 32'h4;
      chk(u_mem.mem[a[9:2]], b ^ 32'h5A5A_0000);
    end
    if (d != 5'h00) begin
      a = a - 32'h4;
      chk(u_mem.mem[a[9:2]], top);
    end
    chk(stack_pointer, a - {16'h0, nb});
    $display("test %s finished", nm);
  endtask
  task automatic t_seg;
    int i;
    for (i = 0; i < 10; i++) begin
      @(posedge clk);
      mem_valid <= 1'b1;
      base_reg <= (i == 9) ? 3'h5 : i[2:0];
      seg_override <= (i >= 8);
      override_seg <= (i == 9) ? nsf_pkg::NSF_SEG_DATA :
                      nsf_pkg::NSF_SEG_STACK;
      @(posedge clk);
      mem_valid <= 1'b0;
      #1;
      chk({30'h0, mem_seg},
          (i == 4 || i == 5 || i == 8) ? 32'h1 : 32'h0);
    end
    $display("test seg finished");
  endtask
  // ========================================
  // Reset in mid-build clears the status, enable, pointer and segment outputs
  task automatic t_reset;
    @(posedge clk);
    slow <= 1'b1;
    load_ptrs <= 1'b1;
    load_sp <= 32'h0000_0200;
    load_fbp <= FBP;
    mem_valid <= 1'b1;
    base_reg <= 3'h5;
    seg_override <= 1'b0;
    @(posedge clk);
    load_ptrs <= 1'b0;
    mem_valid <= 1'b0;
    start <= 1'b1;
    nest_depth <= 5'h04;
    @(posedge clk);
    start <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({30'h0, mem_seg}, 32'h0);
    chk({28'h0, busy, done, wr_en, rd_en}, 32'h0);
    chk(stack_pointer, 32'h0);
    chk(frame_base_pointer, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    $display("test reset finished");
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ========================================
  // Main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    run("flat", 32'h100, 5'h00, 16'h0800, 1'b0, 1'b0);
    run("level1", 32'h2C0, 5'h01, 16'h000C, 1'b1, 1'b0);
    run("nested", 32'h200, 5'h03, 16'h0800, 1'b1, 1'b1);
    run("deep", 32'h400, 5'h1F, 16'hFFFF, 1'b0, 1'b0);
    t_reset;
    run("rerun", 32'h1C0, 5'h02, 16'h0010, 1'b1, 1'b0);
    t_seg;
    report_and_stop;
  end
  initial begin
    #200000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
`default_nettype wire
